// file: inc/ssx_params.svh
/*
 * Constants of the serial port slave-transmit block: register offsets,
 * field positions, reset values and bus widths.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SSX_PARAMS_SVH
`define SSX_PARAMS_SVH

// ****************************************
// Register offsets (word index on the plain register port)
// ****************************************
`define SSX_ADDR_W 3
`define SSX_DATA_W 8
`define SSX_OFF_CTRL1 3'h0
`define SSX_OFF_BUF 3'h1
`define SSX_OFF_STAT 3'h2
`define SSX_OFF_CTRL2 3'h3
`define SSX_OFF_CTRL3 3'h4
`define SSX_OFF_FLAGS 3'h5
`define SSX_OFF_OWNADDR 3'h6

// ****************************************
// Field positions
// ****************************************
`define SSX_CTRL1_WRITE_COLLISION_FLAG 7
`define SSX_CTRL1_OV 6
`define SSX_CTRL1_EN 5
`define SSX_CTRL1_CKP 4
`define SSX_STAT_BF 0
`define SSX_STAT_RW 2
`define SSX_STAT_START 3
`define SSX_STAT_STOP 4
`define SSX_CTRL2_ACK_STATUS_BIT 6
`define SSX_CTRL3_SLAVE_COLLISION_DETECT_ENABLE 2
`define SSX_FLAGS_IRQ 0
`define SSX_FLAGS_BCL 1

// ****************************************
// Reset values and counts
// ****************************************
`define SSX_BYTE_RST 8'h00
`define SSX_MODE_RST 4'h0
`define SSX_OWNADDR_RST 7'h00
`define SSX_BITS_PER_BYTE 4'h8
`define SSX_ACK_SLOT 4'h9

`endif

// file: inc/ssx_pkg.sv
/*
 * Types of the serial port slave-transmit block: mode codes and states.
 * Assumes the constants header sits beside it on the include path.
 */
`include "ssx_params.svh"

package ssx_pkg;

	// ****************************************
	// Port mode select codes
	// ****************************************
	typedef enum logic [3:0] {
		SSX_SPI_M_DIV4 = 4'h0,
		SSX_SPI_M_DIV16 = 4'h1,
		SSX_SPI_M_DIV64 = 4'h2,
		SSX_SPI_M_TMR = 4'h3,
		SSX_SPI_S_SEL = 4'h4,
		SSX_SPI_S_NOSEL = 4'h5,
		SSX_I2C_S7 = 4'h6,
		SSX_I2C_S10 = 4'h7,
		SSX_I2C_M = 4'h8,
		SSX_RSV9 = 4'h9,
		SSX_SPI_M_BAUD = 4'ha,
		SSX_I2C_FW = 4'hb,
		SSX_RSVC = 4'hc,
		SSX_RSVD = 4'hd,
		SSX_I2C_S7_SP = 4'he,
		SSX_I2C_S10_SP = 4'hf
	} ssx_mode_e;

	// Slave link states, Gray coded along idle, address, transmit
	typedef enum logic [1:0] {
		SSX_IDLE = 2'b00,
		SSX_ADDR = 2'b01,
		SSX_TX = 2'b11
	} ssx_state_e;

	typedef logic [`SSX_DATA_W-1:0] ssx_byte_t;

endpackage : ssx_pkg

// file: src/ssx_slave_tx.sv
/*
 * Synchronous serial port, two-wire slave-transmit path with its control,
 * status and flag registers on a plain register port.
 * Assumes SCL and SDA are open-drain wires resolved outside, and that the
 * bus clock is far slower than clk_sys (a few system cycles per half bit).
 */
`timescale 1ns/100ps
`default_nettype none

`include "ssx_params.svh"

module ssx_slave_tx
	import ssx_pkg::*;
#(
	parameter int DATA_W = `SSX_DATA_W
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic rst, // Synchronous reset, high
	input wire logic [`SSX_ADDR_W-1:0] reg_addr, // Register index
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
	input wire logic scl_in, // SCL wire level
	output logic scl_out, // SCL drive value, always low
	output logic scl_oe, // SCL pulled low while high
	input wire logic sda_in, // SDA wire level
	output logic sda_out, // SDA drive value, always low
	output logic sda_oe, // SDA pulled low while high
	output logic pins_owned, // Port owns its pins
	output logic spi_clk_idle // Clock idle level in SPI modes
);

	import ssx_pkg::*;

	// ****************************************
	// Parameter check
	// ****************************************
	if (DATA_W != 8) begin : g_bad_width
		$error("ssx_slave_tx: DATA_W must be 8");
	end

	// ****************************************
	// State
	// ****************************************
	ssx_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic write_collision_flag, ov, en, clock_release_bit;
	logic [3:0] mode;
	logic bf, rw, start_bit, stop_bit, ack_status, slave_collision_detect_enable, irq, bcl, busy;
	logic [6:0] own_addr;
	ssx_byte_t buffer, txsh, rxsh;
	logic scl_s, sda_s, scl_p, sda_p;

	// Pins pass two flops before anything looks at them
	ssx_sync #(.WIDTH(2)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({scl_in, sda_in}),
		.q({scl_s, sda_s})
	);

	// Previous levels for edge detection
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	// ****************************************
	// Decodes
	// ****************************************
	wire sel_ctrl1 = reg_addr == `SSX_OFF_CTRL1;
	wire sel_buf = reg_addr == `SSX_OFF_BUF;
	wire sel_ctrl3 = reg_addr == `SSX_OFF_CTRL3;
	wire sel_flags = reg_addr == `SSX_OFF_FLAGS;
	wire sel_own = reg_addr == `SSX_OFF_OWNADDR;
	wire wr_ctrl1 = reg_wr & sel_ctrl1;
	wire wr_buf = reg_wr & sel_buf;
	wire rd_buf = reg_rd & sel_buf;

	// Mode select groups; reserved codes fall in no group
	wire is_i2c_slave = en & (mode == SSX_I2C_S7 || mode == SSX_I2C_S10
		|| mode == SSX_I2C_S7_SP || mode == SSX_I2C_S10_SP);
	wire is_master = en & (mode == SSX_I2C_M || mode == SSX_I2C_FW);
	wire is_spi = en & (mode <= SSX_SPI_S_NOSEL || mode == SSX_SPI_M_BAUD);
	wire start_irq_en = mode == SSX_I2C_S7_SP || mode == SSX_I2C_S10_SP;

	// Bus edges and conditions
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start_det = en & scl_s & scl_p & sda_p & ~sda_s;
	wire stop_det = en & scl_s & scl_p & ~sda_p & sda_s;
	wire in_addr = state == SSX_ADDR;
	wire in_tx = state == SSX_TX;

	// Address byte decision after the eighth falling edge
	wire addr_hit = rxsh[7:1] == own_addr;
	wire ack_dec = is_i2c_slave & in_addr & scl_fall & (cnt == `SSX_BITS_PER_BYTE) & addr_hit & rxsh[0];
	wire ack_ok = ack_dec & ~bf & ~ov;
	wire ack_ovf = ack_dec & (bf | ov);
	wire ack_end = in_addr & scl_fall & (cnt == `SSX_ACK_SLOT);

	// Transmit phase events
	wire tx_shift = in_tx & scl_fall & (cnt < `SSX_BITS_PER_BYTE);
	wire ack_smp = in_tx & scl_rise & (cnt == `SSX_BITS_PER_BYTE);
	wire byte_end = in_tx & scl_fall & (cnt == `SSX_BITS_PER_BYTE);
	wire collide = in_tx & scl_rise & (cnt < `SSX_BITS_PER_BYTE) & txsh[7] & ~sda_s & slave_collision_detect_enable;

	// A write while the byte is on the wire must not corrupt it
	wire shifting = in_tx & clock_release_bit & (cnt < `SSX_BITS_PER_BYTE);
	wire write_collision_flag_set = wr_buf & ((is_i2c_slave & shifting) | (is_master & busy));
	wire buf_load = wr_buf & ~write_collision_flag_set;
	wire irq_set = ack_end | byte_end | (start_det & start_irq_en);

	// Read data selection; unmapped indices read zero
	wire [DATA_W-1:0] rd_mux =
		sel_ctrl1 ? {write_collision_flag, ov, en, clock_release_bit, mode} :
		sel_buf ? buffer :
		(reg_addr == `SSX_OFF_STAT) ? {3'h0, stop_bit, start_bit, rw, 1'b0, bf} :
		(reg_addr == `SSX_OFF_CTRL2) ? {1'b0, ack_status, 6'h00} :
		sel_ctrl3 ? {5'h00, slave_collision_detect_enable, 2'h0} :
		sel_flags ? {6'h00, bcl, irq} :
		sel_own ? {1'b0, own_addr} : `SSX_BYTE_RST;

	// ****************************************
	// Slave sequence
	// ****************************************
	// Start and Stop override any byte in flight
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (!en) begin
			next_state = SSX_IDLE;
		end else if (stop_det) begin
			next_state = SSX_IDLE;
		end else if (start_det) begin
			next_state = is_i2c_slave ? SSX_ADDR : SSX_IDLE;
			next_cnt = 4'h0;
		end else begin
			case (state)
				SSX_ADDR: begin
					if (scl_rise && cnt < `SSX_BITS_PER_BYTE)
						next_cnt = cnt + 4'h1;
					if (ack_ok) begin
						next_cnt = `SSX_ACK_SLOT;
					end else if (scl_fall && cnt == `SSX_BITS_PER_BYTE) begin
						next_state = SSX_IDLE;
					end else if (ack_end) begin
						next_state = SSX_TX;
						next_cnt = 4'h0;
					end
				end
				SSX_TX: begin
					if (collide) begin
						next_state = SSX_IDLE;
					end else if (tx_shift) begin
						next_cnt = cnt + 4'h1;
					end else if (byte_end) begin
						next_cnt = 4'h0;
						if (ack_status)
							next_state = SSX_IDLE;
					end
				end
				SSX_IDLE: begin
					next_cnt = 4'h0;
				end
				default: begin
					next_state = SSX_IDLE;
					next_cnt = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= SSX_IDLE;
			cnt <= 4'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// ****************************************
	// Shift registers and buffer
	// ****************************************
	// Address bits are taken while SCL is high, so on its rising edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rxsh <= `SSX_BYTE_RST;
		end else if (in_addr && scl_rise && cnt < `SSX_BITS_PER_BYTE) begin
			rxsh <= {rxsh[6:0], sda_s};
		end
	end

	// Shift only after a falling edge keeps SDA steady through SCL high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txsh <= `SSX_BYTE_RST;
		end else if (buf_load) begin
			txsh <= reg_wdata;
		end else if (tx_shift) begin
			txsh <= {txsh[6:0], 1'b0};
		end
	end

	// Overflowed address never reaches the buffer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buffer <= `SSX_BYTE_RST;
		end else if (buf_load) begin
			buffer <= reg_wdata;
		end else if (ack_ok) begin
			buffer <= rxsh;
		end
	end

	// ****************************************
	// Control register one
	// ****************************************
	// Hardware clear of clock release beats a software set in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en <= 1'b0;
			mode <= `SSX_MODE_RST;
			clock_release_bit <= 1'b0;
		end else begin
			if (wr_ctrl1) begin
				en <= reg_wdata[`SSX_CTRL1_EN];
				mode <= reg_wdata[3:0];
				clock_release_bit <= reg_wdata[`SSX_CTRL1_CKP];
			end
			if (ack_end || (byte_end && !ack_status))
				clock_release_bit <= 1'b0;
		end
	end

	// Sticky flags: a hardware set wins over a software clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			write_collision_flag <= 1'b0;
			ov <= 1'b0;
			irq <= 1'b0;
			bcl <= 1'b0;
			bf <= 1'b0;
		end else begin
			write_collision_flag <= (wr_ctrl1 ? reg_wdata[`SSX_CTRL1_WRITE_COLLISION_FLAG] : write_collision_flag) | write_collision_flag_set;
			ov <= (wr_ctrl1 ? reg_wdata[`SSX_CTRL1_OV] : ov) | ack_ovf;
			irq <= ((reg_wr && sel_flags) ? reg_wdata[`SSX_FLAGS_IRQ] : irq) | irq_set;
			bcl <= ((reg_wr && sel_flags) ? reg_wdata[`SSX_FLAGS_BCL] : bcl) | collide;
			bf <= (bf & ~rd_buf) | ack_ok;
		end
	end

	// ****************************************
	// Status, options and own address
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rw <= 1'b0;
			start_bit <= 1'b0;
			stop_bit <= 1'b0;
			busy <= 1'b0;
			ack_status <= 1'b0;
		end else begin
			if (ack_ok)
				rw <= 1'b1;
			if (start_det) begin
				start_bit <= 1'b1;
				stop_bit <= 1'b0;
				busy <= 1'b1;
			end else if (stop_det) begin
				start_bit <= 1'b0;
				stop_bit <= 1'b1;
				busy <= 1'b0;
			end
			if (ack_smp)
				ack_status <= sda_s;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slave_collision_detect_enable <= 1'b0;
			own_addr <= `SSX_OWNADDR_RST;
		end else begin
			if (reg_wr && sel_ctrl3)
				slave_collision_detect_enable <= reg_wdata[`SSX_CTRL3_SLAVE_COLLISION_DETECT_ENABLE];
			if (reg_wr && sel_own)
				own_addr <= reg_wdata[6:0];
		end
	end

	// ****************************************
	// Outputs, all registered
	// ****************************************
	// Pull SDA low for the acknowledge slot and for each zero data bit
	wire next_sda_oe = en & ((in_addr & (cnt == `SSX_ACK_SLOT))
		| (in_tx & (cnt < `SSX_BITS_PER_BYTE) & ~txsh[7]));
	wire next_scl_oe = is_i2c_slave & in_tx & ~clock_release_bit;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= `SSX_BYTE_RST;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			pins_owned <= 1'b0;
			spi_clk_idle <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : `SSX_BYTE_RST;
			sda_oe <= next_sda_oe;
			scl_oe <= next_scl_oe;
			sda_out <= 1'b0;
			scl_out <= 1'b0;
			pins_owned <= en;
			spi_clk_idle <= is_spi & clock_release_bit;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_nack_byte;
		byte_end && ack_status && !start_det && !stop_det;
	endsequence

	sequence s_ack_slot_end;
		ack_end && !start_det && !stop_det;
	endsequence

	chk_read_addr_ack: assert property (
		ack_ok && !start_det && !stop_det |=> rw && bf && buffer == $past(rxsh) ##1 sda_oe)
		else $error("read address not acknowledged");
	chk_stretch_after: assert property (
		s_ack_slot_end and !wr_ctrl1 |=> !clock_release_bit && in_tx ##1 scl_oe)
		else $error("clock not stretched after address");
	chk_buf_loads_tx: assert property (
		buf_load |=> txsh == $past(reg_wdata) && buffer == $past(reg_wdata))
		else $error("buffer write did not load shift register");
	chk_sda_on_fall: assert property (
		in_tx && $changed(txsh) |-> $past(tx_shift) || $past(buf_load))
		else $error("transmit data moved off a falling edge");
	chk_ack_latch: assert property (
		ack_smp |=> ack_status == $past(sda_s))
		else $error("master acknowledge not latched");
	chk_nack_idle: assert property (
		s_nack_byte |=> state == SSX_IDLE && irq ##1 !scl_oe)
		else $error("not-acknowledge did not end transfer");
	chk_irq_ninth: assert property (
		byte_end ##1 !(reg_wr && sel_flags) |-> irq)
		else $error("interrupt flag missing after byte");
	chk_ack_restretch: assert property (
		byte_end && !ack_status && !wr_ctrl1 && en |=> !clock_release_bit)
		else $error("acknowledged byte not stretched");
	chk_collision: assert property (
		collide && !stop_det && !start_det |=> bcl && state == SSX_IDLE)
		else $error("bus collision not handled");
	chk_start_seen: assert property (
		start_det |=> start_bit && !stop_bit && (irq || !start_irq_en || $past(reg_wr)))
		else $error("start condition not recorded");
	chk_read_clears: assert property (
		rd_buf && !ack_ok |=> !bf)
		else $error("buffer read left full flag");
	chk_stop_ends: assert property (
		stop_det |=> state == SSX_IDLE && stop_bit)
		else $error("stop did not end addressing");
	chk_write_coll: assert property (
		write_collision_flag_set |=> write_collision_flag && (txsh == $past(txsh, 1) || $past(tx_shift)))
		else $error("write collision not flagged");
	chk_port_off: assert property (
		!en [*2] |=> !sda_oe && !scl_oe && !pins_owned)
		else $error("disabled port still drives pins");

endmodule : ssx_slave_tx

`default_nettype wire

// file: src/ssx_sync.sv
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level from outside the clk_sys domain.
 */
`timescale 1ns/100ps
`default_nettype none

module ssx_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [WIDTH-1:0] d, // Asynchronous levels
	output logic [WIDTH-1:0] q // Synchronised levels
);

	logic [WIDTH-1:0] meta;

	// ****************************************
	// Width check
	// ****************************************
	if (WIDTH < 1) begin : g_bad_width
		$error("ssx_sync: WIDTH must be at least one");
	end

	// ****************************************
	// One chain per bit; bus idles high so reset to one
	// ****************************************
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				meta[i] <= 1'b1;
				q[i] <= 1'b1;
			end else begin
				meta[i] <= d[i];
				q[i] <= meta[i];
			end
		end
	end

endmodule : ssx_sync

`default_nettype wire

// file: tb/ssx_i2c_master_model.sv
/*
 * Behavioural two-wire bus master that reads from the slave under test.
 * Assumes the bench resolves both open-drain wires with pull-ups.
 */
`timescale 1ns/100ps
`default_nettype none

module ssx_i2c_master_model (
	input wire logic scl, // SCL wire level
	input wire logic sda, // SDA wire level
	output logic scl_low, // Pull SCL low
	output logic sda_low // Pull SDA low
);
	// Both wires released: the clock stands still between frames
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Bounded wait, as a stretching slave may hold the clock low
	task automatic wait_high();
		int n;
		n = 0;
		while (scl !== 1'b1 && n < 20000) begin
			#10;
			n++;
		end
	endtask : wait_high

	// One clock of 400 ns: drive b (1 = release), sample mid-high
	task automatic clk_bit(input logic b, output logic s);
		sda_low = ~b;
		#100;
		scl_low = 1'b0;
		wait_high();
		#100;
		s = sda;
		#100;
		scl_low = 1'b1;
		#100;
	endtask : clk_bit

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], rx[i]);
		end
		clk_bit(ack_in, ack_out);
	endtask : xfer

	// Start: data falls while the clock is high
	task automatic start();
		sda_low = 1'b0;
		scl_low = 1'b0;
		wait_high();
		#200;
		sda_low = 1'b1;
		#200;
		scl_low = 1'b1;
		#100;
	endtask : start

	// Stop: data rises while the clock is high
	task automatic stop();
		sda_low = 1'b1;
		#100;
		scl_low = 1'b0;
		wait_high();
		#200;
		sda_low = 1'b0;
		#200;
	endtask : stop
endmodule : ssx_i2c_master_model

`default_nettype wire

// file: tb/test_ssx_slave_tx.sv
/*
 * Self-checking bench of the slave-transmit block with a bus master model.
 * Assumes the constants header and package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

`include "ssx_params.svh"

module test_ssx_slave_tx;
	import ssx_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, pins_owned, spi_clk_idle;
	logic m_scl_low, m_sda_low;
	wire scl_w;
	wire sda_w;
	int errors = 0;
	int total_checks = 0;
	logic [6:0] own;
	logic [7:0] d, rx, b;
	logic ack;
	logic [7:0] q[$];

	// Pull-up wires: low while any party pulls
	assign scl_w = (scl_oe ? scl_out : 1'b1) & ~m_scl_low;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;

	// 20 MHz system clock
	always #25 clk_sys = ~clk_sys;

	ssx_slave_tx DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.pins_owned(pins_owned), .spi_clk_idle(spi_clk_idle));

	ssx_i2c_master_model mst (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t ns: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic wait_irq();
		int n;
		logic [7:0] f;
		n = 0;
		f = 8'h00;
		while (f[`SSX_FLAGS_IRQ] !== 1'b1 && n < 40) begin
			rd(`SSX_OFF_FLAGS, f);
			n++;
		end
		chk(8'(f[`SSX_FLAGS_IRQ]), 8'h01, "irq flag");
	endtask : wait_irq

	// Start, read address, then the software side of the address byte
	task automatic addr_phase();
		mst.start();
		mst.xfer({own, 1'b1}, 1'b1, rx, ack);
		chk(8'(ack), 8'h00, "address ack");
		wait_irq();
		chk(8'(scl_oe), 8'h01, "stretch");
		rd(`SSX_OFF_CTRL1, d);
		chk(8'(d[`SSX_CTRL1_CKP]), 8'h00, "ckp cleared");
		rd(`SSX_OFF_STAT, d);
		chk(8'(d[`SSX_STAT_RW]), 8'h01, "rw flag");
		rd(`SSX_OFF_BUF, d);
		chk(d, {own, 1'b1}, "address in buffer");
		rd(`SSX_OFF_STAT, d);
		chk(8'(d[`SSX_STAT_BF]), 8'h00, "bf cleared");
		wr(`SSX_OFF_FLAGS, 8'h00);
	endtask : addr_phase

	task automatic tdone(input string name);
		$display("test %s done", name);
	endtask : tdone

	task automatic end_of_test();
		$display("checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// Watchdog, far beyond the expected run of some 1000 cycles
	initial begin
		#3000000;
		errors++;
		$display("[ERR] %0t ns: watchdog expired", $time);
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(45));
		own = 7'($urandom_range(126, 1));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`SSX_OFF_CTRL1, d);
		chk(d, 8'h00, "ctrl1 reset");
		rd(`SSX_OFF_FLAGS, d);
		chk(d, 8'h00, "flags reset");
		wr(3'h7, 8'hff);
		rd(3'h7, d);
		chk(d, 8'h00, "unmapped");
		tdone("reset");
		// Every mode code, enable on odd codes only, clock bit always set
		for (int m = 0; m < 16; m++) begin
			wr(`SSX_OFF_CTRL1, {2'b00, m[0], 1'b1, 4'(m)});
			rd(`SSX_OFF_CTRL1, d);
			chk(d, {2'b00, m[0], 1'b1, 4'(m)}, "mode");
			chk(8'(pins_owned), 8'(m[0]), "pins owned");
			chk(8'(spi_clk_idle), 8'(m[0] && (m < 6 || m == 10)), "spi idle");
			chk(8'({scl_out, sda_out}), 8'h00, "drive values low");
		end
		tdone("modes");
		wr(`SSX_OFF_OWNADDR, {1'b0, own});
		wr(`SSX_OFF_CTRL3, 8'h04);
		rd(`SSX_OFF_CTRL3, d);
		chk(8'(d[`SSX_CTRL3_SLAVE_COLLISION_DETECT_ENABLE]), 8'h01, "slave_collision_detect_enable");
		wr(`SSX_OFF_CTRL1, 8'h36);
		// Start without its interrupt, then a foreign address
		mst.start();
		rd(`SSX_OFF_FLAGS, d);
		chk(8'(d[`SSX_FLAGS_IRQ]), 8'h00, "no start irq");
		rd(`SSX_OFF_STAT, d);
		chk(8'(d[`SSX_STAT_START]), 8'h01, "start seen");
		mst.xfer({own ^ 7'h01, 1'b1}, 1'b1, rx, ack);
		chk(8'(ack), 8'h01, "foreign address");
		mst.stop();
		tdone("mismatch");
		// Three bytes, the last one refused by the master
		addr_phase();
		for (int k = 0; k < 3; k++) begin
			b = 8'($urandom);
			q.push_back(b);
			chk(8'(scl_oe), 8'h01, "held low");
			wr(`SSX_OFF_BUF, b);
			wr(`SSX_OFF_CTRL1, 8'h36);
			mst.xfer(8'hff, k == 2, rx, ack);
			chk(rx, q.pop_front(), "data byte");
			wait_irq();
			wr(`SSX_OFF_FLAGS, 8'h00);
			rd(`SSX_OFF_CTRL2, d);
			chk(8'(d[`SSX_CTRL2_ACK_STATUS_BIT]), 8'(k == 2), "ack_status_bit");
			chk(8'(scl_oe), 8'(k != 2), "stretch after ack");
		end
		mst.xfer(8'hff, 1'b1, rx, ack);
		chk(rx, 8'hff, "idle after nack");
		mst.stop();
		rd(`SSX_OFF_STAT, d);
		chk(8'(d[`SSX_STAT_STOP]), 8'h01, "stop seen");
		tdone("transmit");
		// Buffer write in mid-byte
		addr_phase();
		wr(`SSX_OFF_BUF, 8'h5a);
		wr(`SSX_OFF_CTRL1, 8'h36);
		fork
			mst.xfer(8'hff, 1'b1, rx, ack);
			begin
				repeat (40) @(posedge clk_sys);
				wr(`SSX_OFF_BUF, 8'ha5);
			end
		join
		rd(`SSX_OFF_CTRL1, d);
		chk(8'(d[`SSX_CTRL1_WRITE_COLLISION_FLAG]), 8'h01, "write_collision_flag set");
		wr(`SSX_OFF_CTRL1, 8'h36);
		rd(`SSX_OFF_CTRL1, d);
		chk(8'(d[`SSX_CTRL1_WRITE_COLLISION_FLAG]), 8'h00, "write_collision_flag cleared");
		mst.stop();
		tdone("write collision");
		// Master pulls the first data bit low against a one
		addr_phase();
		wr(`SSX_OFF_BUF, 8'hff);
		wr(`SSX_OFF_CTRL1, 8'h36);
		mst.xfer(8'h7f, 1'b1, rx, ack);
		rd(`SSX_OFF_FLAGS, d);
		chk(8'(d[`SSX_FLAGS_BCL]), 8'h01, "bus collision");
		chk(rx, 8'h7f, "slave idle");
		mst.stop();
		tdone("bus collision");
		// Start interrupt enabled
		wr(`SSX_OFF_FLAGS, 8'h00);
		wr(`SSX_OFF_CTRL1, {4'h3, SSX_I2C_S7_SP});
		mst.start();
		rd(`SSX_OFF_FLAGS, d);
		chk(8'(d[`SSX_FLAGS_IRQ]), 8'h01, "start irq");
		// Master mode with the bus busy refuses a buffer write
		wr(`SSX_OFF_CTRL1, 8'h28);
		wr(`SSX_OFF_BUF, 8'h11);
		rd(`SSX_OFF_CTRL1, d);
		chk(8'(d[`SSX_CTRL1_WRITE_COLLISION_FLAG]), 8'h01, "master write_collision_flag");
		mst.stop();
		tdone("start interrupt");
		end_of_test();
	end
endmodule : test_ssx_slave_tx

`default_nettype wire
